// ===== vsc_top.sv
// Vertical sync source, polarity, filter, duration and coast logic with
// an AXI4-Lite register slave. Assumes all inputs synchronous to clk and
// hsync already polarity-resolved, active high.
//
// Our own choice: the AXI4-Lite register port.

// Idle-level polarity guess: shorter level is taken as active
module vsc_pol_detect (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic level,
  output logic      active_high
);
  logic       level_d;
  logic [7:0] hi_len;
  logic [7:0] lo_len;
  logic [7:0] hi_last;
  logic [7:0] lo_last;

  // Run lengths per level, latched when the level ends
  always_ff @(posedge clk) begin
    if (reset) begin
      level_d <= 1'b0;
      hi_len  <= 8'h00;
      lo_len  <= 8'h00;
      hi_last <= 8'h00;
      lo_last <= 8'hFF;
    end else if (ce) begin
      level_d <= level;
      if (level != level_d) begin
        if (level_d) begin
          hi_last <= hi_len;
          hi_len  <= 8'h00;
        end else begin
          lo_last <= lo_len;
          lo_len  <= 8'h00;
        end
      end else if (tick) begin
        if (level && hi_len != 8'hFF) hi_len <= hi_len + 8'h01;
        if (!level && lo_len != 8'hFF) lo_len <= lo_len + 8'h01;
      end
    end
  end

  assign active_high = hi_last < lo_last;
endmodule : vsc_pol_detect

module vsc_top (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic                hsync,
  input  wire logic                vertical_sync_input_a,
  input  wire logic                vertical_sync_input_b,
  input  wire logic                vertical_pin_select,
  input  wire logic                separator_vsync,
  input  wire logic                external_coast,
  output logic                     vertical_sync_out,
  output logic                     coast_out,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import vsc_pkg::*;

  logic [7:0]  vctl, vlen, pre, post, ccs;
  logic        aw_hold, w_hold;
  logic [5:0]  aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        hs_d, pin_d, filt_q, filt_d, dur_act, period_ok;
  logic [10:0] pin_idle, line_cnt, period;
  logic [1:0]  filt_cnt;
  logic [7:0]  dur_cnt;

  // Horizontal tick and pin activity
  wire hs_tick   = ce & hsync & ~hs_d;
  wire pin       = vertical_pin_select ? vertical_sync_input_b : vertical_sync_input_a;
  wire pin_alive = pin_idle < IDLE_LINES;

  // Source choice: prefer the pin while it toggles
  wire auto_src = ~pin_alive;
  wire src_sel  = vctl[VCTL_OVR] ? vctl[VCTL_SRC] : auto_src;
  wire raw_vs   = src_sel ? separator_vsync : pin;

  wire vs_det_pol, co_det_pol;
  vsc_pol_detect u_vs_pol (
    .clk         (clk),
    .reset       (reset),
    .ce          (ce),
    .tick        (hs_tick),
    .level       (raw_vs),
    .active_high (vs_det_pol)
  );
  vsc_pol_detect u_co_pol (
    .clk         (clk),
    .reset       (reset),
    .ce          (ce),
    .tick        (hs_tick),
    .level       (external_coast),
    .active_high (co_det_pol)
  );

  // Polarity resolution to active high
  wire vpol    = vctl[VCTL_POVR] ? vctl[VCTL_IN_POL] : vs_det_pol;
  wire vs_act  = raw_vs ^ ~vpol;
  wire cpol    = ccs[CCS_POVR] ? ccs[CCS_POL] : co_det_pol;
  wire ext_act = external_coast ^ ~cpol;

  // Shaping and coast window
  wire filt_en   = vctl[VCTL_FILT];
  wire lead      = filt_q & ~filt_d;
  wire vs_shaped = vctl[VCTL_DUR] ? dur_act : filt_q;
  wire [11:0] pre_sum = {1'b0, line_cnt} + {4'h0, pre};
  wire pre_hit   = period_ok & (pre != 8'h00) & (pre_sum >= {1'b0, period});
  wire post_hit  = line_cnt < {3'h0, post};
  wire int_coast = pre_hit | post_hit;

  // Line counters and filter; filter waits whole lines to reject glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      hs_d     <= 1'b0;
      pin_d    <= 1'b0;
      pin_idle <= LINE_MAX;
      filt_q   <= 1'b0;
      filt_d   <= 1'b0;
      filt_cnt <= 2'h0;
    end else if (ce) begin
      hs_d   <= hsync;
      pin_d  <= pin;
      filt_d <= filt_q;
      if (pin != pin_d) pin_idle <= 11'h000;
      else if (hs_tick && pin_idle != LINE_MAX) pin_idle <= pin_idle + 11'h001;
      if (!filt_en || vs_act == filt_q) begin
        filt_q   <= filt_en ? filt_q : vs_act;
        filt_cnt <= 2'h0;
      end else if (hs_tick) begin
        if (filt_cnt == FILT_LINES - 2'h1) begin
          filt_q   <= vs_act;
          filt_cnt <= 2'h0;
        end else begin
          filt_cnt <= filt_cnt + 2'h1;
        end
      end
    end
  end

  // Duration stage and frame period measurement
  always_ff @(posedge clk) begin
    if (reset) begin
      dur_act   <= 1'b0;
      dur_cnt   <= 8'h00;
      line_cnt  <= LINE_MAX;
      period    <= LINE_MAX;
      period_ok <= 1'b0;
    end else if (ce) begin
      if (lead) begin
        dur_act   <= vlen != 8'h00;
        dur_cnt   <= 8'h00;
        period    <= line_cnt;
        period_ok <= line_cnt != LINE_MAX;
        line_cnt  <= 11'h000;
      end else begin
        if (dur_act && hs_tick) begin
          dur_cnt <= dur_cnt + 8'h01;
          if (dur_cnt + 8'h01 == vlen) dur_act <= 1'b0;
        end
        if (hs_tick && line_cnt != LINE_MAX) line_cnt <= line_cnt + 11'h001;
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      vertical_sync_out <= 1'b1;
      coast_out         <= 1'b0;
    end else if (ce) begin
      vertical_sync_out <= vs_shaped ^ ~vctl[VCTL_OUT_POL];
      coast_out         <= ccs[CCS_SRC] ? ext_act : int_coast;
    end
  end

  // Bus decode; readies drop with ce so no beat is lost while frozen
  assign s_axi_awready = ce & ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  wire do_write = ce & aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_ok    = aw_idx >= IDX_VCTL && aw_idx <= IDX_CCS;
  wire wr_lane  = do_write & wr_ok & w_strb[0];
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire [7:0] status = {1'b0, period_ok, coast_out, filt_q, pin_alive,
                       co_det_pol, vs_det_pol, src_sel};
  wire [7:0] rd_mux = (ar_idx == IDX_VCTL) ? vctl :
                      (ar_idx == IDX_VLEN) ? vlen :
                      (ar_idx == IDX_PRE)  ? pre  :
                      (ar_idx == IDX_POST) ? post :
                      (ar_idx == IDX_CCS)  ? ccs  :
                      (ar_idx == IDX_STAT) ? status : 8'h00;
  wire rd_ok = ar_idx >= IDX_VCTL && ar_idx <= IDX_STAT;

  // Write path: address and data taken in either order
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_idx       <= 6'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage; status is read only
  always_ff @(posedge clk) begin
    if (reset) begin
      vctl <= VCTL_RST;
      vlen <= VLEN_RST;
      pre  <= PRE_RST;
      post <= POST_RST;
      ccs  <= CCS_RST;
    end else if (wr_lane) begin
      if (aw_idx == IDX_VCTL) vctl <= {w_data[7:1], 1'b0};
      if (aw_idx == IDX_VLEN) vlen <= w_data[7:0];
      if (aw_idx == IDX_PRE)  pre  <= w_data[7:0];
      if (aw_idx == IDX_POST) post <= w_data[7:0];
      if (aw_idx == IDX_CCS)  ccs  <= w_data[7:0];
    end
  end

  // Read path, one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_mux};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  src_force_a: assert property (@(posedge clk) disable iff (reset)
    vctl[VCTL_OVR] |-> raw_vs == (vctl[VCTL_SRC] ? separator_vsync : pin))
    else $error("forced source not followed");
  src_auto_a: assert property (@(posedge clk) disable iff (reset)
    (!vctl[VCTL_OVR] && pin_alive) |-> raw_vs == pin)
    else $error("live pin not chosen");
  in_pol_a: assert property (@(posedge clk) disable iff (reset)
    vctl[VCTL_POVR] |-> vs_act == (raw_vs ~^ vctl[VCTL_IN_POL]))
    else $error("input polarity wrong");
  out_pol_a: assert property (@(posedge clk) disable iff (reset)
    (ce && !reset) |=> vertical_sync_out == ($past(vs_shaped) ~^ $past(vctl[VCTL_OUT_POL])))
    else $error("output polarity wrong");
  filt_tick_a: assert property (@(posedge clk) disable iff (reset)
    (filt_en && $past(filt_en) && filt_q != $past(filt_q)) |-> $past(hs_tick))
    else $error("filter moved off a line tick");
  dur_start_a: assert property (@(posedge clk) disable iff (reset)
    (ce && lead && vlen != 8'h00) |=> dur_act && dur_cnt == 8'h00)
    else $error("duration did not start");
  dur_end_a: assert property (@(posedge clk) disable iff (reset)
    (ce && !lead && dur_act && hs_tick && dur_cnt == vlen - 8'h01) |=> !dur_act)
    else $error("duration did not end at count");
  coast_sel_a: assert property (@(posedge clk) disable iff (reset)
    ce |=> coast_out == ($past(ccs[CCS_SRC]) ? $past(ext_act) : $past(int_coast)))
    else $error("coast source wrong");
  coast_pol_a: assert property (@(posedge clk) disable iff (reset)
    ccs[CCS_POVR] |-> ext_act == (external_coast ~^ ccs[CCS_POL]))
    else $error("coast polarity wrong");
  post_win_a: assert property (@(posedge clk) disable iff (reset)
    (ce && lead && post != 8'h00) |=> int_coast)
    else $error("post coast missing after edge");
endmodule : vsc_top

// ===== vsc_pkg.sv
// Constants for the vertical sync and coast control block.
// Assumes a single clock; register indices map to byte address index*4.
package vsc_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_VCTL = 6'h14;
  localparam logic [5:0] IDX_VLEN = 6'h15;
  localparam logic [5:0] IDX_PRE  = 6'h16;
  localparam logic [5:0] IDX_POST = 6'h17;
  localparam logic [5:0] IDX_CCS  = 6'h18;
  localparam logic [5:0] IDX_STAT = 6'h19;
  // Vertical control fields
  localparam int VCTL_OVR     = 7;
  localparam int VCTL_SRC     = 6;
  localparam int VCTL_POVR    = 5;
  localparam int VCTL_IN_POL  = 4;
  localparam int VCTL_OUT_POL = 3;
  localparam int VCTL_FILT    = 2;
  localparam int VCTL_DUR     = 1;
  // Coast control fields
  localparam int CCS_SRC  = 7;
  localparam int CCS_POVR = 6;
  localparam int CCS_POL  = 5;
  // Reset values
  localparam logic [7:0] VCTL_RST = 8'h18;
  localparam logic [7:0] VLEN_RST = 8'h0A;
  localparam logic [7:0] PRE_RST  = 8'h00;
  localparam logic [7:0] POST_RST = 8'h00;
  localparam logic [7:0] CCS_RST  = 8'h20;
  // Timing in horizontal periods
  localparam logic [1:0]  FILT_LINES  = 2'h2;
  localparam logic [10:0] IDLE_LINES  = 11'h400;
  localparam logic [10:0] LINE_MAX    = 11'h7FF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vsc_pkg

// ===== vsc_sync_src.sv
// Model of the video source: line sync, vertical sync on a pin and from the separator.
// Assumes a free-running bench clock; 16 clocks a line, 12 lines a frame.
module vsc_sync_src (
  input  wire logic clk,
  input  wire logic act_high,
  output logic      hsync,
  output logic      vsync_pin,
  output logic      vsync_other,
  output logic      separator_vsync
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  initial begin
    hsync = 1'b0;
    vsync_pin = 1'b0;
    vsync_other = 1'b0;
    separator_vsync = 1'b0;
  end
  // Separator active lines 0-3, pin lines 6-9, so the two sources are distinguishable
  always @(posedge clk) begin
    pos <= (pos + 1) % 192;
    hsync <= (pos % 16) < 2;
    separator_vsync <= ((pos / 16) < 4) ~^ act_high;
    vsync_pin <= ((pos / 16) inside {[6:9]}) ~^ act_high;
    vsync_other <= ~vsync_other; // Unused pin toggles, never a stale level
  end
endmodule : vsc_sync_src

// ===== vsc_top_tb.sv
// Self-checking bench for vsc_top: register model, sync path and coast checks.
// Assumes vsc_sync_src drives the sync inputs; AXI4-Lite master in tasks.
module vsc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vsc_pkg::*;
  logic clk = 0, reset = 1, ce = 1, pin_sel = 0, ext_coast = 0, act_high = 1;
  logic hsync, vs_a, vs_b, sep, vs_out, coast;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int failures = 0, comparisons = 0, cyc = 0, seed = 6, i, n;
  int m[5] = '{'h18, 'h0A, 0, 0, 'h20};
  int tbl[4][3] = '{'{'hD8, 0, 1}, '{'h98, 1, 1}, '{'hD0, 0, 0}, '{'hE8, 0, 0}};
  always #50 clk = ~clk;
  vsc_sync_src src (.clk(clk), .act_high(act_high), .hsync(hsync), .vsync_pin(vs_a),
    .vsync_other(vs_b), .separator_vsync(sep));
  vsc_top dut (.clk(clk), .reset(reset), .ce(ce), .hsync(hsync),
    .vertical_sync_input_a(vs_a), .vertical_sync_input_b(vs_b),
    .vertical_pin_select(pin_sel), .separator_vsync(sep), .external_coast(ext_coast),
    .vertical_sync_out(vs_out), .coast_out(coast), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, v}; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    fork
      begin @(posedge clk iff awready); awvalid <= 0; end
      begin @(posedge clk iff wready); wvalid <= 0; end
    join
    @(posedge clk iff bvalid);
    r = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    @(posedge clk iff arready);
    arvalid <= 0;
    @(posedge clk iff rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd
  // Counting over one full frame catches the window wherever it lies
  task automatic count(input bit use_coast);
    n = 0;
    repeat (192) begin
      @(posedge clk);
      #1 if ((use_coast ? coast : vs_out) === 1'b1) n++;
    end
  endtask : count
  // Hang guard; the run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin failures++; conclude(); end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 0;
    // Reset values through the register model
    for (i = 0; i < 5; i++) begin
      rd(8'h50 + 4 * i);
      chk(d, m[i]);
    end
    // Random values into the storage registers
    repeat (10) begin
      i = {$random(seed)} % 5;
      d = $random(seed);
      wr(8'h50 + 4 * i, d[7:0], 4'hF);
      chk(r, RESP_OKAY);
      m[i] = d[7:0] & ((i == 0) ? 'hFE : 'hFF);
      rd(8'h50 + 4 * i);
      chk(d, m[i]);
    end
    // Lane 0 masked leaves the value; unmapped and status writes refused
    wr(8'h58, 8'h55, 4'hE);
    rd(8'h58);
    chk(d, m[2]);
    wr(8'h70, 8'h01, 4'hF);
    chk(r, RESP_SLVERR);
    rd(8'h70);
    chk(r, RESP_SLVERR);
    chk(d, 0);
    wr(8'h64, 8'h01, 4'hF);
    chk(r, RESP_SLVERR);
    // Frozen: every ready held low
    @(posedge clk);
    ce <= 0;
    @(posedge clk);
    #1 chk({awready, wready, arready}, 0);
    @(posedge clk);
    ce <= 1;
    // Second pin, forced source and polarity: output follows two edges later
    pin_sel <= 1;
    wr(8'h50, 8'hB8, 4'hF);
    @(posedge clk);
    #1 n = vs_b;
    repeat (2) @(posedge clk);
    #1 chk(vs_out, n);
    @(posedge clk);
    pin_sel <= 0;
    // Long wait lets the detectors relatch whole runs after the source change
    wr(8'h50, 8'h18, 4'hF);
    repeat (400) @(posedge clk);
    rd(8'h64);
    chk(d[1:0], 2'h2);
    wr(8'h50, 8'hD8, 4'hF);
    rd(8'h64);
    chk(d[0], 1);
    act_high <= 0;
    repeat (800) @(posedge clk);
    rd(8'h64);
    chk(d[1], 0);
    act_high <= 1;
    // Each setting settles two frames before the edge is watched
    for (i = 0; i < 4; i++) begin
      wr(8'h50, tbl[i][0][7:0], 4'hF);
      repeat (400) @(posedge clk);
      if (tbl[i][1]) @(posedge vs_a);
      else @(posedge sep);
      @(posedge clk);
      #1 chk(vs_out, !tbl[i][2]);
      @(posedge clk);
      #1 chk(vs_out, tbl[i][2]);
    end
    // First frame absorbs the switch-over, second is measured
    wr(8'h50, 8'hDC, 4'hF);
    count(0);
    count(0);
    chk(n inside {[60:68]}, 1);
    wr(8'h54, 8'h03, 4'hF);
    wr(8'h50, 8'hDE, 4'hF);
    count(0);
    count(0);
    chk(n inside {[40:56]}, 1);
    for (i = 0; i < 4; i++) begin
      wr(8'h60, (i % 2) ? 8'hC0 : 8'hE0, 4'hF);
      ext_coast <= i < 2;
      repeat (3) @(posedge clk);
      #1 chk(coast, (i == 0) || (i == 3));
    end
    wr(8'h60, 8'h00, 4'hF);
    wr(8'h58, 8'h00, 4'hF);
    wr(8'h5C, 8'h00, 4'hF);
    count(1);
    chk(n, 0);
    wr(8'h5C, 8'h02, 4'hF);
    count(1);
    count(1);
    chk(n inside {[16:48]}, 1);
    wr(8'h58, 8'h02, 4'hF);
    count(1);
    count(1);
    chk(n inside {[48:112]}, 1);
    conclude();
  end
endmodule : vsc_top_tb
